// [logic/i2ctc_evt_if.sv]
`timescale 1ns/1ps
interface i2ctc_evt_if;
  import i2ctc_pkg::*;
  logic [NUM_EV-1:0] evt;
  logic              statWr;
  logic              maskWr;
  logic [NUM_EV-1:0] wdata;
  logic              isrRd;
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] mask;
  logic [2:0]        code;
  logic              irq;
  modport ctl (output evt, statWr, maskWr, wdata, isrRd, input status, mask, code, irq);
  modport isr (input evt, statWr, maskWr, wdata, isrRd, output status, mask, code, irq);
endinterface

// [logic/i2ctc_int_source.sv]
`timescale 1ns/1ps
module i2ctc_int_source
  import i2ctc_pkg::*;
(
  input wire logic    sys_clk,
  input wire logic    rst,
  i2ctc_evt_if.isr    ev
);

  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] mask;
  logic              irqReg;

  // Pending flags, reported code and the flag a source read drops
  wire [NUM_EV-1:0] pend   = status & mask;
  wire [2:0]        code   = prioCode(pend);
  wire [NUM_EV-1:0] w1c    = ev.statWr ? ev.wdata : '0;
  wire [NUM_EV-1:0] rdClr  = (ev.isrRd && code != 3'h0) ? NUM_EV'(1 << (code - 3'h1)) : '0;

  // Sticky flags; a new event beats any clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      mask   <= '0;
      irqReg <= 1'b0;
    end else begin
      status <= (status & ~(w1c | rdClr)) | ev.evt;
      mask   <= ev.maskWr ? ev.wdata : mask;
      irqReg <= |pend;
    end
  end

  assign ev.status = status;
  assign ev.mask   = mask;
  assign ev.code   = code;
  assign ev.irq    = irqReg;

  AST_ISR_CLEARS: assert property (@(posedge sys_clk) disable iff (rst)
    (ev.isrRd && code != 3'h0 && !ev.evt[code - 3'h1]) |=> !status[$past(code) - 3'h1])
    else $error("source read did not clear the reported flag");

  AST_ISR_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
    (ev.isrRd && !ev.statWr) |=> (($past(status) & ~$past(rdClr)) & ~status) == '0)
    else $error("source read dropped a lower priority flag");

  AST_CODE_PRIO: assert property (@(posedge sys_clk) disable iff (rst)
    (pend != '0) |-> (code != 3'h0 && pend[code - 3'h1] && (pend & ((7'h01 << (code - 3'h1)) - 7'h01)) == '0))
    else $error("code is not the highest priority pending flag");

  AST_IRQ_REFIRE: assert property (@(posedge sys_clk) disable iff (rst)
    (ev.isrRd && (pend & ~rdClr) != '0) |=> ##1 ev.irq)
    else $error("no fresh interrupt while flags remain pending");

endmodule

// [logic/i2ctc_pkg.sv]
package i2ctc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_WCOUNT = 8'h04;
  localparam logic [7:0] OFF_SADDR  = 8'h08;
  localparam logic [7:0] OFF_OADDR  = 8'h0C;
  localparam logic [7:0] OFF_TXD    = 8'h10;
  localparam logic [7:0] OFF_RXD    = 8'h14;
  localparam logic [7:0] OFF_STAT   = 8'h18;
  localparam logic [7:0] OFF_MASK   = 8'h1C;
  localparam logic [7:0] OFF_ISR    = 8'h28;

  // Mode register field positions
  localparam int BC_LSB  = 0;
  localparam int FF_BIT  = 3;
  localparam int RM_BIT  = 7;
  localparam int DIR_BIT = 9;
  localparam int MST_BIT = 10;
  localparam int STP_BIT = 11;
  localparam int STT_BIT = 13;

  // Reset values
  localparam logic [31:0] MODE_RST   = 32'h0000_0000;
  localparam logic [15:0] WCOUNT_RST = 16'h0001;
  localparam logic [6:0]  ADDR_RST   = 7'h00;
  localparam logic [7:0]  DATA_RST   = 8'h00;

  // Event flag positions, code = position + 1
  localparam int NUM_EV  = 7;
  localparam int EV_AL   = 0;
  localparam int EV_NACK = 1;
  localparam int EV_ARDY = 2;
  localparam int EV_RRDY = 3;
  localparam int EV_XRDY = 4;
  localparam int EV_SCD  = 5;
  localparam int EV_AAS  = 6;

  // Bus half period
  localparam int CLK_NS   = 40;
  localparam int HALF_NS  = 5000;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_START, ST_XFER, ST_STOP, ST_WAIT} i2ctc_state_t;

  // Bits per word, code 0 means eight
  function automatic logic [3:0] wordBits(input logic [2:0] bc);
    wordBits = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction

  // Right-justified word moved up to shift out MSB first
  function automatic logic [7:0] txAlign(input logic [7:0] d, input logic [2:0] bc);
    txAlign = d << (4'h8 - wordBits(bc));
  endfunction

  // Lowest set position wins, reported as position + 1
  function automatic logic [2:0] prioCode(input logic [NUM_EV-1:0] p);
    prioCode = 3'h0;
    for (int i = NUM_EV - 1; i >= 0; i--) begin
      if (p[i]) begin
        prioCode = 3'(i + 1);
      end
    end
  endfunction

endpackage

// [logic/i2ctc_transfer_control.sv]
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module i2ctc_transfer_control
  import i2ctc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe
);

  i2ctc_evt_if evIf ();

  // Software state
  logic [2:0]  bitCnt;
  logic        freeFmt, repeatSel, dirSel, mstSel, stopReq, startReq;
  logic [15:0] wordCount;
  logic [6:0]  slvAddr, ownAddr;
  logic [7:0]  txData, rxData;
  logic        wrPend;
  logic [7:0]  wrAddr;
  logic [31:0] rdMux;

  // Bus line sampling
  logic sclM, sclS, sclP, sdaM, sdaS, sdaP;

  // Engine state
  i2ctc_state_t state, next_state;
  logic [1:0]   step, next_step;
  logic [7:0]   tickCnt;
  logic         sclLow, next_sclLow, sdaLow, next_sdaLow;
  logic [7:0]   shReg, next_sh;
  logic [3:0]   bitLeft, next_bitLeft;
  logic         ackPh, next_ackPh, isAddr, next_isAddr, amTx, next_amTx, ackSeen, next_ackSeen;
  logic [15:0]  cntLeft, next_cnt;
  logic         clrStart, clrStop, rxLoad;
  logic [NUM_EV-1:0] evtSet;

  // Address phase decode and write strobes
  wire addrAcc  = hsel & htrans[1] & hready;
  wire mapped   = (haddr[31:8] == 24'h0);
  wire wrMode   = wrPend && wrAddr == OFF_MODE;
  wire wrCount  = wrPend && wrAddr == OFF_WCOUNT;
  wire wrSaddr  = wrPend && wrAddr == OFF_SADDR;
  wire wrOaddr  = wrPend && wrAddr == OFF_OADDR;
  wire wrTx     = wrPend && wrAddr == OFF_TXD;
  wire isrRead  = addrAcc && !hwrite && mapped && haddr[7:0] == OFF_ISR;

  // Line events seen through the synchronisers
  wire sclRise  = sclS & ~sclP;
  wire sclFall  = ~sclS & sclP;
  wire busStart = sclS & sclP & sdaP & ~sdaS;
  wire busStop  = sclS & sclP & ~sdaP & sdaS;
  wire tick     = (tickCnt == HALF_LAST);
  wire reserved = repeatSel & startReq & stopReq;
  wire lastWord = !repeatSel && cntLeft == 16'h0001;
  wire [3:0] nBits   = wordBits(bitCnt);
  wire [7:0] txFirst = txAlign(txData, bitCnt);
  wire ticking  = state == ST_START || state == ST_STOP || (state == ST_XFER && mstSel);
  wire stretch  = state == ST_XFER && !sclLow && !sclS;

  assign evIf.evt    = evtSet;
  assign evIf.statWr = wrPend && wrAddr == OFF_STAT;
  assign evIf.maskWr = wrPend && wrAddr == OFF_MASK;
  assign evIf.wdata  = hwdata[NUM_EV-1:0];
  assign evIf.isrRd  = isrRead;

  i2ctc_int_source uIsr (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ev      (evIf.isr)
  );

  // Read mux, unmapped words read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    if (!mapped) begin
      rdMux = 32'h0000_0000;
    end else if (haddr[7:0] == OFF_MODE) begin
      rdMux = {18'h0, startReq, 1'b0, stopReq, mstSel, dirSel, 1'b0, repeatSel, 3'h0, freeFmt, bitCnt};
    end else if (haddr[7:0] == OFF_WCOUNT) begin
      rdMux = {16'h0, wordCount};
    end else if (haddr[7:0] == OFF_SADDR) begin
      rdMux = {25'h0, slvAddr};
    end else if (haddr[7:0] == OFF_OADDR) begin
      rdMux = {25'h0, ownAddr};
    end else if (haddr[7:0] == OFF_TXD) begin
      rdMux = {24'h0, txData};
    end else if (haddr[7:0] == OFF_RXD) begin
      rdMux = {24'h0, rxData};
    end else if (haddr[7:0] == OFF_STAT) begin
      rdMux = {25'h0, evIf.status};
    end else if (haddr[7:0] == OFF_MASK) begin
      rdMux = {25'h0, evIf.mask};
    end else if (haddr[7:0] == OFF_ISR) begin
      rdMux = {29'h0, evIf.code};
    end
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPend    <= 1'b0;
      wrAddr    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wrPend    <= addrAcc & hwrite & mapped;
      wrAddr    <= haddr[7:0];
      hrdata    <= (addrAcc && !hwrite) ? rdMux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Mode register; hardware drops start and stop requests once served
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {startReq, stopReq, mstSel, dirSel} <= 4'h0;
      {repeatSel, freeFmt}                <= 2'h0;
      bitCnt                              <= MODE_RST[BC_LSB +: 3];
    end else if (wrMode) begin
      startReq  <= hwdata[STT_BIT];
      stopReq   <= hwdata[STP_BIT];
      mstSel    <= hwdata[MST_BIT];
      dirSel    <= hwdata[DIR_BIT];
      repeatSel <= hwdata[RM_BIT];
      freeFmt   <= hwdata[FF_BIT];
      bitCnt    <= hwdata[BC_LSB +: 3];
    end else begin
      startReq  <= startReq & ~clrStart;
      stopReq   <= stopReq & ~clrStop;
    end
  end

  // Data and address registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wordCount <= WCOUNT_RST;
      slvAddr   <= ADDR_RST;
      ownAddr   <= ADDR_RST;
      txData    <= DATA_RST;
      rxData    <= DATA_RST;
    end else begin
      wordCount <= wrCount ? hwdata[15:0] : wordCount;
      slvAddr   <= wrSaddr ? hwdata[6:0] : slvAddr;
      ownAddr   <= wrOaddr ? hwdata[6:0] : ownAddr;
      txData    <= wrTx ? hwdata[7:0] : txData;
      rxData    <= rxLoad ? shReg : rxData;
    end
  end

  // Line synchronisers and previous samples
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {sclM, sclS, sclP} <= 3'b111;
      {sdaM, sdaS, sdaP} <= 3'b111;
    end else begin
      {sclM, sclS, sclP} <= {sclIn, sclM, sclS};
      {sdaM, sdaS, sdaP} <= {sdaIn, sdaM, sdaS};
    end
  end

  // Half-period timer, held in ST_XFER while another party stretches the clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tickCnt <= 8'h00;
    end else if (!ticking || tick) begin
      tickCnt <= 8'h00;
    end else if (!stretch) begin
      tickCnt <= tickCnt + 8'h01;
    end
  end

  // Sequencer
  always_comb begin
    next_state   = state;
    next_step    = step;
    next_sclLow  = sclLow;
    next_sdaLow  = sdaLow;
    next_sh      = shReg;
    next_bitLeft = bitLeft;
    next_ackPh   = ackPh;
    next_isAddr  = isAddr;
    next_amTx    = amTx;
    next_ackSeen = ackSeen;
    next_cnt     = cntLeft;
    clrStart     = 1'b0;
    clrStop      = 1'b0;
    rxLoad       = 1'b0;
    evtSet       = '0;
    evtSet[EV_SCD] = busStop;
    case (state)
      ST_IDLE, ST_HOLD: begin
        if (mstSel && startReq && !reserved) begin
          next_state = ST_START;
          next_step  = 2'd0;
          clrStart   = 1'b1;
        end else if (mstSel && stopReq && !startReq) begin
          next_state = ST_STOP;
          next_step  = 2'd0;
        end else if (!mstSel && busStart && state == ST_IDLE) begin
          // slave path never looks at repeat
          next_state   = ST_XFER;
          next_isAddr  = !freeFmt;
          next_amTx    = freeFmt & dirSel;
          next_bitLeft = freeFmt ? nBits : 4'h8;
          next_sh      = (freeFmt & dirSel) ? txFirst : 8'h00;
          next_ackPh   = 1'b0;
        end
      end
      ST_START: begin
        if (tick) begin
          next_step = step + 2'd1;
          case (step)
            2'd0: next_sdaLow = 1'b0;
            2'd1: next_sclLow = 1'b0;
            2'd2: next_sdaLow = 1'b1;
            default: begin
              next_sclLow  = 1'b1;
              next_state   = ST_XFER;
              next_cnt     = wordCount;
              next_isAddr  = !freeFmt;
              next_ackPh   = 1'b0;
              next_amTx    = freeFmt ? dirSel : 1'b1;
              next_bitLeft = freeFmt ? nBits : 4'h8;
              next_sh      = !freeFmt ? {slvAddr, ~dirSel} : (dirSel ? txFirst : 8'h00);
              // First bit must stand before the clock rises
              next_sdaLow  = !freeFmt ? ~slvAddr[6] : (dirSel & ~txFirst[7]);
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          next_step = step + 2'd1;
          case (step)
            2'd0: begin
              next_sclLow = 1'b1;
              next_sdaLow = 1'b1;
            end
            2'd1: next_sclLow = 1'b0;
            default: begin
              next_sdaLow = 1'b0;
              next_state  = ST_IDLE;
              clrStop     = 1'b1;
            end
          endcase
        end
      end
      ST_WAIT: begin
        if (busStop || busStart) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        if (mstSel && tick) begin
          next_sclLow = ~sclLow;
        end
        if (!mstSel && (busStop || busStart)) begin
          next_state  = ST_IDLE;
          next_sdaLow = 1'b0;
        end else if (sclRise) begin
          if (ackPh) begin
            next_ackSeen = ~sdaS;
          end else if (mstSel && amTx && !sdaLow && !sdaS) begin
            evtSet[EV_AL] = 1'b1;
            next_state    = ST_IDLE;
            next_sclLow   = 1'b0;
            next_sdaLow   = 1'b0;
          end else begin
            next_sh      = {shReg[6:0], sdaS};
            next_bitLeft = bitLeft - 4'h1;
          end
        end else if (sclFall && !ackPh) begin
          if (bitLeft == 4'h0) begin
            next_ackPh  = 1'b1;
            next_sdaLow = 1'b0;
            if (isAddr && !mstSel) begin
              if (shReg[7:1] == ownAddr) begin
                evtSet[EV_AAS] = 1'b1;
                next_sdaLow    = 1'b1;
              end else begin
                next_state = ST_WAIT;
              end
            end else if (!isAddr && !amTx) begin
              rxLoad         = 1'b1;
              evtSet[EV_RRDY] = 1'b1;
              next_sdaLow    = !(mstSel && (lastWord || (repeatSel && stopReq)));
            end
          end else begin
            next_sdaLow = amTx & ~shReg[7];
          end
        end else if (sclFall) begin
          next_ackPh   = 1'b0;
          next_sdaLow  = 1'b0;
          next_bitLeft = nBits;
          if (isAddr) begin
            next_isAddr = 1'b0;
            if (mstSel && !ackSeen) begin
              evtSet[EV_NACK] = 1'b1;
              next_state      = ST_STOP;
              next_step       = 2'd0;
            end else begin
              // plain slave takes the master's command bit
              next_amTx   = mstSel ? dirSel : shReg[0];
              next_sh     = (mstSel ? dirSel : shReg[0]) ? txFirst : 8'h00;
              next_sdaLow = (mstSel ? dirSel : shReg[0]) & ~txFirst[7];
            end
          end else if (amTx && !ackSeen) begin
            evtSet[EV_NACK] = mstSel;
            next_state      = mstSel ? ST_STOP : ST_WAIT;
            next_step       = 2'd0;
          end else begin
            evtSet[EV_XRDY] = amTx;
            next_sh         = amTx ? txFirst : 8'h00;
            next_sdaLow     = amTx & ~txFirst[7];
            if (mstSel && !repeatSel) begin
              next_cnt = cntLeft - 16'h0001;
              if (lastWord) begin
                evtSet[EV_ARDY] = 1'b1;
                next_sdaLow     = 1'b0;
                next_state      = stopReq ? ST_STOP : ST_HOLD;
                next_step       = 2'd0;
              end
            end else if (mstSel && (stopReq || startReq)) begin
              // repeat runs until stop or new start
              next_sdaLow = 1'b0;
              next_state  = stopReq ? ST_STOP : ST_HOLD;
              next_step   = 2'd0;
            end
          end
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state   <= ST_IDLE;
      step    <= 2'd0;
      {sclLow, sdaLow, ackPh, isAddr, amTx, ackSeen} <= 6'h00;
      shReg   <= 8'h00;
      bitLeft <= 4'h0;
      cntLeft <= 16'h0000;
    end else begin
      state   <= next_state;
      step    <= next_step;
      {sclLow, sdaLow, ackPh, isAddr, amTx, ackSeen} <=
        {next_sclLow, next_sdaLow, next_ackPh, next_isAddr, next_amTx, next_ackSeen};
      shReg   <= next_sh;
      bitLeft <= next_bitLeft;
      cntLeft <= next_cnt;
    end
  end

  // Open-drain pins: drive low only while enabled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {sclOe, sdaOe, sclOut, sdaOut, irq} <= 5'h00;
    end else begin
      sclOe  <= next_sclLow;
      sdaOe  <= next_sdaLow;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      irq    <= evIf.irq;
    end
  end

  AST_WORD_BITS: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_XFER && !isAddr && ackPh && sclFall && next_state == ST_XFER) |=> bitLeft == $past(nBits))
    else $error("word length does not follow the bit count field");

  AST_RX_JUSTIFY: assert property (@(posedge sys_clk) disable iff (rst)
    rxLoad |=> rxData == $past(shReg))
    else $error("received word not stored as shifted");

  AST_START_GO: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && mstSel && startReq && !reserved) |=> state == ST_START ##[1:600] state == ST_XFER)
    else $error("start request did not open a frame");

  AST_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_IDLE && reserved && !wrMode) |=> state == ST_IDLE && !sclOe && !sdaOe)
    else $error("reserved combination produced bus activity");

  AST_REPEAT_RUNS: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_XFER && mstSel && repeatSel && !stopReq && !startReq) |=> state != ST_HOLD)
    else $error("repeat mode stopped on the word count");

  AST_COUNT_END: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_XFER && next_state == ST_HOLD && !repeatSel) |-> cntLeft == 16'h0001)
    else $error("transfer ended before the count reached zero");

  AST_FREE_ROLE: assert property (@(posedge sys_clk) disable iff (rst)
    (state == ST_START && step == 2'd3 && tick && freeFmt) |=> amTx == $past(dirSel))
    else $error("free format role not taken from direction select");

endmodule

// [test/i2c_transfer_control_test.sv]
`timescale 1ns/1ps
module i2c_transfer_control_test;
  import i2ctc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  nBits = 4'h8;
  logic        hreadyout, hresp, irq, sclOe, sdaOe, sdaPull, busy;
  logic [31:0] hrdata;
  logic [7:0]  rxAddr, rxWord;
  int          errTotal = 0;
  int          nTests = 0;
  // Open-drain lines with pull-ups
  wire         sclLine = ~sclOe;
  wire         sdaLine = ~(sdaOe | sdaPull);
  always #20 sys_clk = ~sys_clk;

  i2ctc_transfer_control dut_u (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine),
    .sdaOut(), .sdaOe(sdaOe)
  );
  i2ctc_far_end far_u (
    .scl(sclLine), .sda(sdaLine), .nBits(nBits), .sdaPull(sdaPull), .busy(busy),
    .rxAddr(rxAddr), .rxWord(rxWord)
  );

  task automatic finalReport();
    $display("Checks %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait on the ready line
  task automatic waitRdy();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      errTotal++;
      finalReport();
    end
  endtask
  // Bounded wait on the far end's frame flag
  task automatic waitBusy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= lim) begin
      errTotal++;
      finalReport();
    end
  endtask
  // Single word: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask

  // Reset values and an unmapped place
  task automatic resetVals();
    rdChk("mode", OFF_MODE, 32'h0);
    rdChk("count", OFF_WCOUNT, 32'h1);
    rdChk("source", OFF_ISR, 32'h0);
    rdChk("unmapped", 8'h24, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Repeat, start and stop together: bus stays quiet
  task automatic reservedCombo();
    logic seen;
    seen = 1'b0;
    wr(OFF_MODE, 32'h2E80);
    repeat (400) begin
      @(posedge sys_clk);
      seen = seen | sclOe | sdaOe;
    end
    chk("bus quiet", 32'h0, {31'h0, seen});
    wr(OFF_MODE, 32'h0);
  endtask
  // Master write of one word, then source reads
  task automatic xfer(input logic [2:0] bc);
    int n;
    logic [7:0] d;
    n = (bc == 3'h0) ? 8 : int'(bc);
    d = 8'hA5 & (8'hFF >> (8 - n));
    nBits <= 4'(n);
    wr(OFF_SADDR, 32'h2A);
    wr(OFF_WCOUNT, 32'h1);
    wr(OFF_MASK, 32'h14);
    wr(OFF_TXD, {24'h0, d});
    wr(OFF_MODE, {18'h0, 14'h2E00 | {11'h0, bc}});
    waitBusy(1'b1, 3000);
    waitBusy(1'b0, 12000);
    chk("address byte", 32'h54, {24'h0, rxAddr});
    chk("data word", {24'h0, d}, {24'h0, rxWord});
    repeat (8) @(posedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(OFF_MASK, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_MASK, 32'h14);
    rdChk("source first", OFF_ISR, 32'h3);
    repeat (4) @(posedge sys_clk);
    chk("irq again", 32'h1, {31'h0, irq});
    rdChk("source second", OFF_ISR, 32'h5);
    rdChk("source empty", OFF_ISR, 32'h0);
    repeat (4) @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  // Repeat mode ignores the count; second word is not acked
  task automatic repeatRun();
    nBits <= 4'h8;
    wr(OFF_MASK, 32'h0);
    wr(OFF_TXD, 32'h3C);
    wr(OFF_MODE, 32'h2680);
    waitBusy(1'b1, 3000);
    waitBusy(1'b0, 12000);
    chk("repeat word", 32'h3C, {24'h0, rxWord});
    rdChk("repeat status", OFF_STAT, 32'h32);
    wr(OFF_STAT, 32'h7F);
    rdChk("status cleared", OFF_STAT, 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    resetVals();
    reservedCombo();
    for (int b = 0; b < 8; b++) begin
      xfer(3'(b));
    end
    repeatRun();
    finalReport();
  end
endmodule

// [test/i2ctc_far_end.sv]
`timescale 1ns/1ps
// Bus target: acks the address byte and one word
module i2ctc_far_end (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [3:0] nBits,
  output logic            sdaPull,
  output logic            busy,
  output logic [7:0]      rxAddr,
  output logic [7:0]      rxWord
);
  int cnt = 0;
  // Quiet until the first start
  initial begin
    sdaPull = 1'b0;
    busy = 1'b0;
  end
  // Start: data falls while clock high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      busy = 1'b1;
      cnt = -1;
      rxAddr = 8'h00;
      rxWord = 8'h00;
    end
  end
  // Stop: data rises while clock high
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      busy = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (busy && cnt < 8) begin
      rxAddr = {rxAddr[6:0], sda};
    end else if (busy && cnt > 8 && cnt < 9 + nBits) begin
      rxWord = {rxWord[6:0], sda};
    end
  end
  // Ack slots pull data low for one bit
  always @(negedge scl) begin
    if (busy) begin
      cnt++;
      sdaPull = (cnt == 8) || (cnt == 9 + nBits);
    end
  end
endmodule
